// *** logic/tth_pkg.sv ***
// Purpose: Shared constants and types for the thermal throttle block.
// Assumes: 10 MHz pclk, APB with 32-bit data and 12-bit byte address.
// Notes: All offsets, reset values and timing counts live here.
`default_nettype none
package tth_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned NUM_CORES = 2;

	// Register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_MASK = 12'h008;
	localparam logic [11:0] ADDR_STATE = 12'h00c;

	// Status and mask bit positions
	localparam int unsigned ST_OVERHEAT = 0;
	localparam int unsigned ST_HOT_ASSERT = 1;
	localparam int unsigned ST_HOT_DEASSERT = 2;
	localparam int unsigned STATUS_W = 3;

	// Control register layout, high bits first
	typedef struct packed {
		logic irq_on_deassert;
		logic irq_on_assert;
		logic [1:0] ps_en;
		logic [1:0] cm_en;
	} tth_ctrl_type;
	localparam int unsigned CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h0f;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	// Throttle decision per core
	typedef struct packed {
		logic [1:0] modulate;
		logic [1:0] lowperf;
	} tth_throttle_type;

	// Persistence of a trip before the overheat flag latches
	localparam int unsigned OVERHEAT_TIME_NS = 100000;
	localparam int unsigned OVERHEAT_CYC = OVERHEAT_TIME_NS / CLK_PERIOD_NS;
	// Half period of the fixed 50% clock modulation
	localparam int unsigned MOD_HALF_TIME_NS = 1000;
	localparam int unsigned MOD_HALF_CYC = MOD_HALF_TIME_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** logic/tth_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous levels.
// Assumes: Inputs are slow levels, no multi-bit coherence needed.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none
module tth_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// Two stages against metastability
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule
`default_nettype wire

// *** logic/tth_duty.sv ***
// Purpose: Fixed 50% on/off phase for core clock modulation.
// Assumes: Half period is MOD_HALF_CYC pclk cycles.
// Notes: Phase restarts in the on half whenever modulation stops.
`timescale 1ns/1ns
`default_nettype none
module tth_duty
	import tth_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic phase_off
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic off_ff;
	logic nxt_off;
	logic [7:0] off_len_ff;
	logic [7:0] nxt_off_len;

	// Equal on and off halves, so the duty cannot drift
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_off = off_ff;
		if (!run) begin
			nxt_cnt = 8'h00;
			nxt_off = 1'b0;
		end else if (cnt_ff == 8'(MOD_HALF_CYC - 1)) begin
			nxt_cnt = 8'h00;
			nxt_off = ~off_ff;
		end else begin
			nxt_cnt = cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
			off_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			off_ff <= nxt_off;
		end
	end

	assign phase_off = off_ff;

	// Length of the running off half; helper for the duty check only
	always_comb begin
		nxt_off_len = 8'h00;
		if (off_ff) begin
			nxt_off_len = off_len_ff + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_len_ff <= 8'h00;
		end else begin
			off_len_ff <= nxt_off_len;
		end
	end

	// An off half cut short by a stop is exempt; a full one is exact
	property p_duty;
		@(posedge pclk) disable iff (!presetn)
		$fell(off_ff) && $past(run) |-> off_len_ff == 8'(MOD_HALF_CYC);
	endproperty
	a_duty: assert property (p_duty) else $error("modulation half period wrong");
endmodule
`default_nettype wire

// *** logic/tth_top.sv ***
// Purpose: Package-level thermal throttle control with a two-way hot alarm pin.
// Assumes: Sensor trips and the pin are asynchronous; APB on pclk at 10 MHz.
// Notes: Pin is open drain; the bench resolves its level from the enable.
// Summary of operation
// - Trip persisting under throttling latches sticky overheat flag and interrupts.
// - Hot alarm pin asserted while die reaches maximum temperature.
// - Control circuit active while pin asserted if a method enabled.
// - Interrupt selectable on pin asserting edge, deasserting edge, or both.
// - External pin assertion activates control circuit even when not hot.
// - One shared pin, driven when either core sensor trips.
// - Clock modulation only: modulate just the tripped core.
// - Performance-state throttling: both cores go to lowest state on trip.
// - External request, clock modulation on both cores: modulate both.
// - External request, performance state on both cores: both go lowest.
// - Modulation gates clocks with fixed 50% duty while active.
`timescale 1ns/1ns
`default_nettype none
module tth_top
	import tth_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] core_trip,
	input wire logic hot_alarm_n_i,
	output logic hot_alarm_n_o,
	output logic hot_alarm_n_oe,
	output logic [1:0] core_clk_run,
	output logic [1:0] core_lowperf,
	output logic thermal_control_circuit,
	output logic irq
);
	logic [1:0] trip_s;
	logic pin_s;
	logic phase_off;

	// Sensor trips and pin level cross into pclk
	tth_sync #(.W(2), .RST_VAL(2'b00)) u_trip_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(core_trip),
		.dout(trip_s)
	);
	tth_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(hot_alarm_n_i),
		.dout(pin_s)
	);

	// Register state
	tth_ctrl_type ctrl_ff;
	tth_ctrl_type nxt_ctrl;
	logic [2:0] status_ff;
	logic [2:0] nxt_status;
	logic [2:0] mask_ff;
	logic [2:0] nxt_mask;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pready_ff;
	logic nxt_pready;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic irq_ff;
	logic nxt_irq;

	// Pin and throttle state
	logic drive_ff;
	logic nxt_drive;
	logic [1:0] drive_hist_ff;
	logic [1:0] nxt_drive_hist;
	logic pin_low_d_ff;
	logic tcc_ff;
	logic nxt_tcc;
	logic [1:0] clk_run_ff;
	logic [1:0] nxt_clk_run;
	logic [1:0] lowperf_ff;
	logic [1:0] nxt_lowperf;
	logic [9:0] oh_cnt_ff;
	logic [9:0] nxt_oh_cnt;

	logic trip_any;
	logic ext_req;
	logic any_en;
	logic hot_rise;
	logic hot_fall;
	logic oh_set;
	tth_throttle_type thr;
	logic [2:0] set_ev;
	logic acc;
	logic wr;
	logic hit;

	// Own drive shows on pin_s two cycles later; mask that echo out
	assign trip_any = |trip_s;
	assign ext_req = ~pin_s & ~drive_hist_ff[1];
	assign any_en = |{ctrl_ff.cm_en, ctrl_ff.ps_en};
	assign hot_rise = ~pin_s & ~pin_low_d_ff;
	assign hot_fall = pin_s & pin_low_d_ff;

	// Throttle choice; performance state takes precedence over modulation
	always_comb begin
		thr = '0;
		if (trip_any && |ctrl_ff.ps_en) begin
			thr.lowperf = 2'b11;
		end else if (trip_any) begin
			thr.modulate = trip_s & ctrl_ff.cm_en;
		end
		if (ext_req && &ctrl_ff.ps_en) begin
			thr.lowperf = 2'b11;
		end else if (ext_req && &ctrl_ff.cm_en && !(trip_any && |ctrl_ff.ps_en)) begin
			thr.modulate = 2'b11;
		end
	end

	// Pin drive, control circuit and core outputs
	always_comb begin
		nxt_drive = trip_any;
		nxt_drive_hist = {drive_hist_ff[0], drive_ff};
		nxt_tcc = any_en & (trip_any | ext_req);
		nxt_lowperf = thr.lowperf;
		nxt_clk_run = ~(thr.modulate & {2{phase_off}});
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_ff <= 1'b0;
			drive_hist_ff <= 2'b00;
			pin_low_d_ff <= 1'b0;
			tcc_ff <= 1'b0;
			lowperf_ff <= 2'b00;
			clk_run_ff <= 2'b11;
		end else begin
			drive_ff <= nxt_drive;
			drive_hist_ff <= nxt_drive_hist;
			pin_low_d_ff <= ~pin_s;
			tcc_ff <= nxt_tcc;
			lowperf_ff <= nxt_lowperf;
			clk_run_ff <= nxt_clk_run;
		end
	end

	// Fixed-duty phase runs only while some core is modulated
	tth_duty u_duty (
		.pclk(pclk),
		.presetn(presetn),
		.run(|thr.modulate),
		.phase_off(phase_off)
	);

	// Overheat persistence counter; saturates, restarts when trip clears
	always_comb begin
		nxt_oh_cnt = oh_cnt_ff;
		oh_set = 1'b0;
		if (!(trip_any && any_en)) begin
			nxt_oh_cnt = 10'h000;
		end else if (oh_cnt_ff == 10'(OVERHEAT_CYC - 1)) begin
			oh_set = 1'b1;
		end else begin
			nxt_oh_cnt = oh_cnt_ff + 10'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oh_cnt_ff <= 10'h000;
		end else begin
			oh_cnt_ff <= nxt_oh_cnt;
		end
	end

	// APB slave with no wait state; access phase always completes at once
	assign acc = psel & ~penable;
	assign wr = psel & penable & pwrite & pready_ff;
	assign hit = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_MASK) |
		(paddr == ADDR_STATE);
	assign set_ev = {hot_fall & ctrl_ff.irq_on_deassert, hot_rise & ctrl_ff.irq_on_assert,
		oh_set};

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_pready = acc;
		nxt_pslverr = acc & ~hit;
		nxt_prdata = 32'h00000000;
		// Set wins over a write-one clear in the same cycle
		nxt_status = status_ff | set_ev;
		if (wr && paddr == ADDR_CTRL) begin
			nxt_ctrl = pwdata[CTRL_W-1:0];
		end
		if (wr && paddr == ADDR_MASK) begin
			nxt_mask = pwdata[STATUS_W-1:0];
		end
		if (wr && paddr == ADDR_STATUS) begin
			nxt_status = (status_ff & ~pwdata[STATUS_W-1:0]) | set_ev;
		end
		if (acc && !pwrite) begin
			case (paddr)
				ADDR_CTRL: begin
					nxt_prdata = {26'h0, ctrl_ff};
				end
				ADDR_STATUS: begin
					nxt_prdata = {29'h0, status_ff};
				end
				ADDR_MASK: begin
					nxt_prdata = {29'h0, mask_ff};
				end
				ADDR_STATE: begin
					nxt_prdata = {24'h000000, lowperf_ff, ext_req, drive_ff, trip_s, tcc_ff,
						~pin_s};
				end
				default: begin
					nxt_prdata = 32'h00000000;
				end
			endcase
		end
		nxt_irq = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			status_ff <= STATUS_RST;
			mask_ff <= MASK_RST;
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			irq_ff <= nxt_irq;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign hot_alarm_n_o = 1'b0 & drive_ff;
	assign hot_alarm_n_oe = drive_ff;
	assign core_clk_run = clk_run_ff;
	assign core_lowperf = lowperf_ff;
	assign thermal_control_circuit = tcc_ff;

	// Checks on the throttle and pin behaviour
	sequence s_trip_held;
		(trip_any && any_en) [*8];
	endsequence

	property p_oh_latch;
		@(posedge pclk) disable iff (!presetn)
		oh_set |=> status_ff[ST_OVERHEAT];
	endproperty
	a_oh_latch: assert property (p_oh_latch) else $error("overheat flag not latched");

	property p_oh_wait;
		@(posedge pclk) disable iff (!presetn)
		$rose(status_ff[ST_OVERHEAT]) |-> $past(oh_set);
	endproperty
	a_oh_wait: assert property (p_oh_wait) else $error("overheat set too early");

	property p_drive;
		@(posedge pclk) disable iff (!presetn)
		trip_any |=> hot_alarm_n_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("pin not driven on trip");

	property p_tcc_hold;
		@(posedge pclk) disable iff (!presetn)
		(any_en && (ext_req || trip_any)) |=> thermal_control_circuit;
	endproperty
	a_tcc_hold: assert property (p_tcc_hold) else $error("control circuit inactive");

	property p_edge_irq;
		@(posedge pclk) disable iff (!presetn)
		(hot_rise && ctrl_ff.irq_on_assert) |=> status_ff[ST_HOT_ASSERT];
	endproperty
	a_edge_irq: assert property (p_edge_irq) else $error("assert edge not flagged");

	property p_cm_only;
		@(posedge pclk) disable iff (!presetn)
		(ctrl_ff.ps_en == 2'b00 && !ext_req && $onehot(trip_s) && phase_off) |=>
			core_clk_run == ~$past(trip_s & ctrl_ff.cm_en);
	endproperty
	a_cm_only: assert property (p_cm_only) else $error("wrong core modulated");

	property p_lowperf;
		@(posedge pclk) disable iff (!presetn)
		s_trip_held ##0 (|ctrl_ff.ps_en) |=> core_lowperf == 2'b11;
	endproperty
	a_lowperf: assert property (p_lowperf) else $error("cores not in lowest state");

	property p_ext_cm;
		@(posedge pclk) disable iff (!presetn)
		(ext_req && ctrl_ff.cm_en == 2'b11 && ctrl_ff.ps_en == 2'b00 && phase_off) |=>
			core_clk_run == 2'b00;
	endproperty
	a_ext_cm: assert property (p_ext_cm) else $error("external request not modulating");

	property p_ext_ps;
		@(posedge pclk) disable iff (!presetn)
		(ext_req && ctrl_ff.ps_en == 2'b11) |=> core_lowperf == 2'b11;
	endproperty
	a_ext_ps: assert property (p_ext_ps) else $error("external request not lowering");

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		(!trip_any && !ext_req) |=> !thermal_control_circuit;
	endproperty
	a_release: assert property (p_release) else $error("control circuit stuck");
endmodule
`default_nettype wire

// *** verif/tth_monitor.sv ***
// Purpose: External thermal monitor that may pull the hot alarm pin low.
// Assumes: Pin is open drain with a pull-up resolved by the bench.
// Notes: Pull length is set per request, so it can be brief or long.
`timescale 1ns/1ns
`default_nettype none
module tth_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [7:0] len,
	output logic pull_oe
);
	logic [7:0] cnt_ff;

	// Burst counter; a new request is ignored until the burst ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 8'h00;
		end else if (go && cnt_ff == 8'h00) begin
			cnt_ff <= len;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end

	// Only ever pulls low, never drives high
	assign pull_oe = (cnt_ff != 8'h00);
endmodule
`default_nettype wire

// *** verif/thermal_throttle_hot_pin_bench.sv ***
// Purpose: Self-checking bench for the thermal throttle block.
// Assumes: APB master on pclk; open-drain pin with a pull-up.
// Notes: Bus answers are checked by a watcher against queued notes.
`timescale 1ns/1ns
`default_nettype none
module thermal_throttle_hot_pin_bench
	import tth_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [1:0] core_trip, core_clk_run, core_lowperf;
	logic hot_alarm_n_o, hot_alarm_n_oe, thermal_control_circuit, mon_go, mon_oe;
	logic [7:0] mon_len;
	logic [32:0] note;
	wire logic hot_line;
	int error_cnt, compares, idx;
	logic [32:0] exp_q[$];

	// Pull-up wins unless someone sinks the line
	assign hot_line = ~((hot_alarm_n_oe & ~hot_alarm_n_o) | mon_oe);

	tth_top tth_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_trip(core_trip), .hot_alarm_n_i(hot_line),
		.hot_alarm_n_o(hot_alarm_n_o), .hot_alarm_n_oe(hot_alarm_n_oe),
		.core_clk_run(core_clk_run), .core_lowperf(core_lowperf),
		.thermal_control_circuit(thermal_control_circuit), .irq(irq));
	tth_monitor tth_monitor_i (.pclk(pclk), .presetn(presetn), .go(mon_go), .len(mon_len),
		.pull_oe(mon_oe));

	// Clock
	initial pclk = 1'b0;
	always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

	task automatic conclude();
		$display("Errors %0d, comparisons %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_bus(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: bus expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic chk_pin(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: pins expected %h got %h", $time, exp, got);
		end
	endtask

	// Throttle outputs as one word: tcc, drive, irq, lowperf, clk_run
	function automatic logic [6:0] snap();
		return {thermal_control_circuit, hot_alarm_n_oe, irq, core_lowperf, core_clk_run};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Land on a falling edge so registered outputs have settled
	task automatic probe(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	// One APB transfer; entered right after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic err);
		int n;
		exp_q.push_back({err, exp});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("Error at %0t: ready expected %h got %h", $time, 1'b1, pready);
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next setup never re-drives psel in this step
		@(posedge pclk);
	endtask

	// Off pattern on entering the gated half, then both half lengths
	task automatic measure(input int c, input logic [1:0] off_pat);
		int n;
		n = 0;
		while (core_clk_run[c] !== 1'b0 && n < 40) begin @(negedge pclk); n++; end
		chk_pin(32'(off_pat), 32'(core_clk_run));
		n = 0;
		while (core_clk_run[c] === 1'b0 && n < 40) begin @(negedge pclk); n++; end
		chk_pin(32'(MOD_HALF_CYC), 32'(n));
		n = 0;
		while (core_clk_run[c] === 1'b1 && n < 40) begin @(negedge pclk); n++; end
		chk_pin(32'(MOD_HALF_CYC), 32'(n));
		@(posedge pclk);
	endtask

	task automatic pull(input logic [7:0] len);
		mon_len <= len;
		mon_go <= 1'b1;
		tick(1);
		mon_go <= 1'b0;
	endtask

	// Watcher: each completed transfer is matched to the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("Error at %0t: unexpected answer %h vs %h", $time, prdata, 32'h0);
			end else begin
				note = exp_q.pop_front();
				chk_bus({31'h0, note[32]}, {31'h0, pslverr});
				if (!pwrite) chk_bus(note[31:0], prdata);
			end
		end
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
		pwdata = 32'h0; core_trip = 2'b00; mon_go = 1'b0; mon_len = 8'h00;
		error_cnt = 0; compares = 0;
		rnd = $urandom(32'hc912);
		tick(10);
		presetn <= 1'b1;
		tick(1);
		// Reset values, read-only and unmapped places
		apb(1'b0, ADDR_CTRL, 32'h0, {26'h0, CTRL_RST}, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
		apb(1'b0, ADDR_MASK, 32'h0, 32'h0, 1'b0);
		apb(1'b1, ADDR_STATE, $urandom, 32'h0, 1'b0);
		apb(1'b0, ADDR_STATE, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 12'h010, $urandom, 32'h0, 1'b1);
		apb(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1);
		probe(1);
		chk_pin(32'h03, 32'(snap()));
		tick(1);
		// Modulation only: the tripped core alone is gated
		rnd = $urandom;
		idx = int'(rnd[0]);
		apb(1'b1, ADDR_CTRL, {rnd[31:6], 6'h03}, 32'h0, 1'b0);
		apb(1'b0, ADDR_CTRL, 32'h0, 32'h03, 1'b0);
		core_trip <= 2'b01 << idx;
		probe(8);
		chk_pin(32'hc, 32'({thermal_control_circuit, hot_alarm_n_oe, core_lowperf}));
		measure(idx, ~(2'b01 << idx));
		core_trip <= 2'b00;
		probe(8);
		chk_pin(32'h03, 32'(snap()));
		tick(1);
		// Performance state wins; a long trip latches the sticky flag
		apb(1'b1, ADDR_MASK, {rnd[31:3], 3'h1}, 32'h0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0f, 32'h0, 1'b0);
		core_trip <= (rnd[2:1] == 2'b00) ? 2'b10 : rnd[2:1];
		probe(8);
		chk_pin(32'h6f, 32'(snap()));
		probe(OVERHEAT_CYC + 20);
		chk_pin(32'h1, 32'(irq));
		tick(1);
		core_trip <= 2'b00;
		probe(8);
		chk_pin(32'h1, 32'(irq));
		tick(1);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h1, 1'b0);
		apb(1'b1, ADDR_STATUS, 32'h1, 32'h0, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
		// Outside pull with modulation on both cores and edge events
		apb(1'b1, ADDR_MASK, 32'h6, 32'h0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h33, 32'h0, 1'b0);
		pull(8'd100);
		probe(8);
		chk_pin(32'h43, 32'(snap() & 7'h63));
		chk_pin(32'h1, 32'(irq));
		tick(1);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h2, 1'b0);
		probe(0);
		measure(0, 2'b00);
		tick(100);
		probe(0);
		chk_pin(32'h13, 32'(snap() & 7'h5f));
		tick(1);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h6, 1'b0);
		apb(1'b1, ADDR_STATUS, 32'h6, 32'h0, 1'b0);
		// Outside pull with performance state on both cores
		apb(1'b1, ADDR_CTRL, 32'h0c, 32'h0, 1'b0);
		pull(8'd30);
		probe(8);
		chk_pin(32'h4f, 32'(snap()));
		tick(40);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b0);
		// No method enabled: a pull leaves the control circuit idle
		apb(1'b1, ADDR_CTRL, 32'h00, 32'h0, 1'b0);
		pull(8'd30);
		probe(8);
		chk_pin(32'h03, 32'(snap()));
		tick(40);
		conclude();
	end
endmodule
`default_nettype wire
